// ===== hdl/jcs_jog_cmd_set.sv
`timescale 1ns/10ps
`include "jcs_params.svh"

module jcs_jog_cmd_set
  import jcs_pkg::*;
#(
  parameter int SWITCH_CYC = `JCS_SWITCH_CYC,
  parameter int SEC_CYC    = `JCS_SEC_CYC
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // Pins and controller inputs
  input  wire logic [7:0] dig_in,
  input  wire logic       ready_to_start,
  input  wire logic       motor_on_other,
  input  wire logic [2:0] inch_select_bit0,
  input  wire logic [2:0] inch_select_bit1,
  input  wire logic [2:0] command_set_sel_bit0,
  input  wire logic [2:0] command_set_sel_bit1,
  // Settings
  input  wire jcs_cfg_t   cfg,
  input  wire logic [3:0] commissioning_phase,
  input  wire logic [2:0] count_req,
  input  wire jcs_copy_t  command_set_copy,
  // Status
  output logic            jog_motor_on,
  output jcs_speed_t      ramp_out,
  output logic [1:0]      active_command_set,
  output logic [2:0]      command_set_count,
  output logic            copy_busy,
  output logic            copy_done
);

  // ------------------------------------------------------------
  // Input synchroniser: three stages, change on 2nd/3rd agree
  // ------------------------------------------------------------
  logic [7:0] s1_q, s2_q, s3_q, din_q;
  logic [7:0] s1_d, s2_d, s3_d, din_d;

  always_comb begin
    s1_d  = dig_in;
    s2_d  = s1_q;
    s3_d  = s2_q;
    din_d = din_q;
    for (int i = 0; i < 8; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        din_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s1_q  <= 8'h00;
      s2_q  <= 8'h00;
      s3_q  <= 8'h00;
      din_q <= 8'h00;
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      din_q <= din_d;
    end
  end

  // Routed select bits
  logic jog1, jog2, csel0, csel1;
  assign jog1  = din_q[inch_select_bit0];
  assign jog2  = din_q[inch_select_bit1];
  assign csel0 = din_q[command_set_sel_bit0];
  assign csel1 = din_q[command_set_sel_bit1];

  // ------------------------------------------------------------
  // Jog state machine
  // ------------------------------------------------------------
  jcs_state_t st_q, st_d;
  logic       dir2_q, dir2_d;

  always_comb begin
    st_d   = st_q;
    dir2_d = dir2_q;
    unique case (st_q)
      JCS_IDLE: begin
        // Jog needs ready state and no other ON source
        if ((jog1 || jog2) && ready_to_start && !motor_on_other) begin
          st_d   = JCS_INCH;
          dir2_d = !jog1;
        end
      end
      JCS_INCH: begin
        if (!(dir2_q ? jog2 : jog1)) begin
          st_d = JCS_STOP;
        end
      end
      JCS_STOP: begin
        if (ramp_out == 16'sh0000) begin
          st_d = JCS_IDLE;
        end
      end
      default: begin
        st_d = JCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q   <= JCS_IDLE;
      dir2_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      dir2_q <= dir2_d;
    end
  end

  assign jog_motor_on = (st_q != JCS_IDLE);

  // ------------------------------------------------------------
  // Setpoint processing
  // ------------------------------------------------------------
  jcs_speed_t raw_sp, inv_sp, lim_sp, target;

  always_comb begin
    raw_sp = dir2_q ? cfg.inch_speed_two : cfg.inch_speed_one;
    inv_sp = cfg.setpoint_negate ? -raw_sp : raw_sp;
    lim_sp = inv_sp;
    if (inv_sp > cfg.speed_ceiling) begin
      lim_sp = cfg.speed_ceiling;
    end else if (inv_sp < -cfg.speed_ceiling) begin
      lim_sp = -cfg.speed_ceiling;
    end
    if (cfg.negative_dir_block && lim_sp < 16'sh0000) begin
      lim_sp = 16'sh0000;
    end
    if (cfg.positive_dir_block && lim_sp > 16'sh0000) begin
      lim_sp = 16'sh0000;
    end
    target = (st_q == JCS_INCH) ? lim_sp : 16'sh0000;
  end

  // ------------------------------------------------------------
  // Ramp generator: one rpm step per (time*SEC_CYC/ceiling) clocks
  // ------------------------------------------------------------
  logic [47:0] rstep_q, rstep_d;
  logic [47:0] step_len;
  jcs_speed_t  ramp_q, ramp_d;
  logic        rising;

  always_comb begin
    // Leaving standstill is a ramp-up in either direction
    rising = (ramp_q < 16'sh0000 || (ramp_q == 16'sh0000 && target < 16'sh0000))
             ? (target < ramp_q) : (target > ramp_q);
    step_len = (48'(rising ? cfg.ramp_up_time : cfg.ramp_down_time) * 48'(SEC_CYC))
               / 48'(cfg.speed_ceiling == 16'sh0000 ? 16'sh0001 : cfg.speed_ceiling);
    rstep_d = rstep_q + 48'd1;
    ramp_d  = ramp_q;
    if (target == ramp_q) begin
      rstep_d = 48'd0;
    end else if (rstep_q + 48'd1 >= step_len) begin
      rstep_d = 48'd0;
      ramp_d  = (target > ramp_q) ? ramp_q + 16'sh0001 : ramp_q - 16'sh0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rstep_q <= 48'd0;
      ramp_q  <= 16'sh0000;
    end else begin
      rstep_q <= rstep_d;
      ramp_q  <= ramp_d;
    end
  end

  assign ramp_out = ramp_q;

  // ------------------------------------------------------------
  // Command set count, only in data-set phase
  // ------------------------------------------------------------
  logic [2:0] cnt_q, cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (commissioning_phase == `JCS_PHASE_SETS && count_req >= `JCS_SET_COUNT_MIN
        && count_req <= `JCS_SET_COUNT_MAX) begin
      cnt_d = count_req;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_q <= `JCS_SET_COUNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign command_set_count = cnt_q;

  // ------------------------------------------------------------
  // Command set switchover with delay
  // ------------------------------------------------------------
  logic [1:0]  act_q, act_d, pend_q, pend_d;
  logic [31:0] sw_q, sw_d;
  logic [1:0]  req_idx;
  logic        req_ok;

  always_comb begin
    req_idx = {csel1, csel0};
    req_ok  = ({1'b0, req_idx} < cnt_q);
    act_d   = act_q;
    pend_d  = pend_q;
    sw_d    = sw_q;
    if (req_ok && req_idx != pend_q) begin
      pend_d = req_idx;
      sw_d   = (req_idx != act_q) ? 32'(SWITCH_CYC) : 32'd0;
    end else if (sw_q != 32'd0) begin
      sw_d = sw_q - 32'd1;
      if (sw_q == 32'd1) begin
        act_d = pend_q;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      act_q  <= 2'd0;
      pend_q <= 2'd0;
      sw_q   <= 32'd0;
    end else begin
      act_q  <= act_d;
      pend_q <= pend_d;
      sw_q   <= sw_d;
    end
  end

  assign active_command_set = act_q;

  // ------------------------------------------------------------
  // Copy: two-cycle sequence, busy then done pulse
  // ------------------------------------------------------------
  logic busy_q, busy_d, done_q, done_d;

  always_comb begin
    busy_d = busy_q;
    done_d = 1'b0;
    if (busy_q) begin
      busy_d = 1'b0;
      done_d = 1'b1;
    end else if (command_set_copy.start && !done_q) begin
      busy_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign copy_busy = busy_q;
  assign copy_done = done_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence jog_req_s;
    (jog1 || jog2) && ready_to_start && !motor_on_other && st_q == JCS_IDLE;
  endsequence

  sequence set_req_s;
    req_ok && req_idx != pend_q && req_idx != act_q;
  endsequence

  sequence copy_run_s;
    busy_q ##1 (done_q && !busy_q);
  endsequence

  jog_start_a: assert property (@(posedge ref_clk) disable iff (srst)
    jog_req_s |=> jog_motor_on) else $error("jog did not start");
  jog_stop_a: assert property (@(posedge ref_clk) disable iff (srst)
    st_q == JCS_INCH && !(dir2_q ? jog2 : jog1) |=> st_q == JCS_STOP && target == 16'sh0000)
    else $error("jog release not ramped down");
  motor_off_a: assert property (@(posedge ref_clk) disable iff (srst)
    st_q == JCS_IDLE |-> ramp_q == 16'sh0000)
    else $error("motor off while ramp not at standstill");
  jog_blocked_a: assert property (@(posedge ref_clk) disable iff (srst)
    st_q == JCS_IDLE && motor_on_other |=> !jog_motor_on)
    else $error("jog started over other command");
  ceiling_a: assert property (@(posedge ref_clk) disable iff (srst)
    st_q == JCS_INCH |-> lim_sp <= cfg.speed_ceiling && lim_sp >= -cfg.speed_ceiling)
    else $error("setpoint over ceiling");
  neg_block_a: assert property (@(posedge ref_clk) disable iff (srst)
    cfg.negative_dir_block |-> lim_sp >= 16'sh0000)
    else $error("negative setpoint passed");
  pos_block_a: assert property (@(posedge ref_clk) disable iff (srst)
    cfg.positive_dir_block |-> lim_sp <= 16'sh0000)
    else $error("positive setpoint passed");
  ramp_step_a: assert property (@(posedge ref_clk) disable iff (srst)
    ramp_q != $past(ramp_q) |-> ramp_q - $past(ramp_q) == 16'sh0001
      || $past(ramp_q) - ramp_q == 16'sh0001) else $error("ramp jumped");
  set_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    !req_ok |=> pend_q == $past(pend_q)) else $error("refused set taken");
  set_delay_a: assert property (@(posedge ref_clk) disable iff (srst)
    set_req_s |=> sw_q == 32'(SWITCH_CYC)) else $error("switch delay not loaded");
  set_change_a: assert property (@(posedge ref_clk) disable iff (srst)
    act_q != $past(act_q) |-> $past(sw_q) == 32'd1 && act_q == $past(pend_q))
    else $error("set changed before delay ran out");
  copy_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
    !busy_q && command_set_copy.start && !done_q |=> copy_run_s)
    else $error("copy did not finish");
  count_lock_a: assert property (@(posedge ref_clk) disable iff (srst)
    commissioning_phase != `JCS_PHASE_SETS |=> $stable(cnt_q))
    else $error("count changed outside phase");
  count_take_a: assert property (@(posedge ref_clk) disable iff (srst)
    commissioning_phase == `JCS_PHASE_SETS && count_req >= `JCS_SET_COUNT_MIN
      && count_req <= `JCS_SET_COUNT_MAX |=> cnt_q == $past(count_req))
    else $error("count request not taken");

endmodule

// ===== hdl/jcs_params.svh
`ifndef JCS_PARAMS_SVH
`define JCS_PARAMS_SVH

// Setpoint format: signed rpm, 16 bits
`define JCS_SPD_W            16
`define JCS_INCH_ONE_RST     16'sd150
`define JCS_INCH_TWO_RST     -16'sd150
`define JCS_CEILING_RST      16'sd1500
`define JCS_RAMP_TIME_RST    16'd10
`define JCS_SET_COUNT_RST    3'd2
`define JCS_SET_COUNT_MIN    3'd2
`define JCS_SET_COUNT_MAX    3'd4
`define JCS_PHASE_SETS       4'hF
`define JCS_PHASE_READY      4'h0
`define JCS_SEL_BIT0_RST     3'd0
`define JCS_SEL_BIT1_RST     3'd1

// Timing at 40 MHz
`define JCS_CLK_NS           25
`define JCS_SWITCH_NS        4000000
`define JCS_SWITCH_CYC       (`JCS_SWITCH_NS / `JCS_CLK_NS)
`define JCS_SEC_NS           1000000000
`define JCS_SEC_CYC          (`JCS_SEC_NS / `JCS_CLK_NS)
`define JCS_CYC_W            32

`endif

// ===== hdl/jcs_pkg.sv
package jcs_pkg;
  typedef logic signed [15:0] jcs_speed_t;

  typedef struct packed {
    jcs_speed_t  inch_speed_one;
    jcs_speed_t  inch_speed_two;
    jcs_speed_t  speed_ceiling;
    logic        negative_dir_block;
    logic        positive_dir_block;
    logic        setpoint_negate;
    logic [15:0] ramp_up_time;
    logic [15:0] ramp_down_time;
  } jcs_cfg_t;

  typedef struct packed {
    logic [1:0] src;
    logic [1:0] dst;
    logic       start;
  } jcs_copy_t;

  typedef enum logic [1:0] {
    JCS_IDLE,
    JCS_INCH,
    JCS_STOP
  } jcs_state_t;
endpackage

// ===== tb/jcs_jog_cmd_set_tb_top.sv
`timescale 1ns/10ps
`include "jcs_params.svh"
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module jcs_jog_cmd_set_tb_top
  import jcs_pkg::*;
;
  localparam int SW = 20;
  logic       ref_clk = 1'b0;
  logic       srst = 1'b1;
  logic       ready_to_start = 1'b1;
  logic       motor_on_other = 1'b0;
  logic [1:0] jog = 2'h0;
  logic [1:0] idx = 2'h0;
  jcs_cfg_t   cfg;
  logic [3:0] phase = 4'h0;
  logic [2:0] count_req = 3'h2;
  jcs_copy_t  cp = '0;
  logic [7:0] dig_in;
  logic       jog_motor_on;
  jcs_speed_t ramp_out;
  logic [1:0] active;
  logic [2:0] count;
  logic       copy_busy;
  logic       copy_done;
  int         n_mismatch = 0;
  int         total_checks = 0;
  int         exp_set = 0;
  int         cnt = 2;
  int         t;
  int         sb;

  always #12.5 ref_clk = ~ref_clk;

  jcs_partner partner (.ref_clk(ref_clk), .ready_to_start(ready_to_start), .jog(jog),
                       .idx(idx), .dig_in(dig_in));

  jcs_jog_cmd_set #(.SWITCH_CYC(SW), .SEC_CYC(100)) dut (
    .ref_clk(ref_clk), .srst(srst), .dig_in(dig_in), .ready_to_start(ready_to_start),
    .motor_on_other(motor_on_other), .inch_select_bit0(3'd0), .inch_select_bit1(3'd1),
    .command_set_sel_bit0(3'd2), .command_set_sel_bit1(3'd3), .cfg(cfg),
    .commissioning_phase(phase), .count_req(count_req), .command_set_copy(cp),
    .jog_motor_on(jog_motor_on), .ramp_out(ramp_out), .active_command_set(active),
    .command_set_count(count), .copy_busy(copy_busy), .copy_done(copy_done));

  // ------------------------------------------------------------
  // Model and helpers
  // ------------------------------------------------------------
  function automatic int target(int two, jcs_cfg_t c);
    int v;
    v = two ? int'(c.inch_speed_two) : int'(c.inch_speed_one);
    if (c.setpoint_negate) v = -v;
    if (v > c.speed_ceiling) v = c.speed_ceiling;
    if (v < -c.speed_ceiling) v = -c.speed_ceiling;
    if ((v < 0 && c.negative_dir_block) || (v > 0 && c.positive_dir_block)) v = 0;
    return v;
  endfunction

  task automatic chk(string what, logic signed [31:0] e, logic signed [31:0] s);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, e, s);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic set_sel(logic [1:0] v);
    int e;
    e = (v < cnt) ? v : exp_set;
    @(posedge ref_clk) idx <= v;
    cyc(SW);
    chk("active early", exp_set, active);
    for (int i = 0; i < 16 && active !== e; i++) cyc(1);
    chk("active set", e, active);
    exp_set = e;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #(25ns * 60000);
    n_mismatch++;
    print_verdict();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    cfg = '{`JCS_INCH_ONE_RST, `JCS_INCH_TWO_RST, `JCS_CEILING_RST, 1'b0, 1'b0, 1'b0,
            `JCS_RAMP_TIME_RST, `JCS_RAMP_TIME_RST};
    void'($urandom(51861));
    cyc(5);
    chk("count rst", 2, count);
    chk("ramp rst", 0, ramp_out);
    @(posedge ref_clk) srst <= 1'b0;
    cyc(2);
    chk("active rst", 0, active);
    for (int k = 0; k < 8; k++) begin
      sb = $urandom_range(0, 1);
      @(posedge ref_clk) begin
        cfg.setpoint_negate <= k[0];
        cfg.negative_dir_block <= k[1];
        cfg.positive_dir_block <= k[2];
        if (k > 1) cfg.speed_ceiling <= 16'sd100;
        if (k > 1) cfg.inch_speed_one <= 16'($urandom_range(0, 600)) - 16'sd300;
        if (k > 1) cfg.inch_speed_two <= 16'($urandom_range(0, 600)) - 16'sd300;
        jog <= sb ? 2'h2 : 2'h1;
      end
      cyc(1);
      t = target(sb, cfg);
      for (int i = 0; i < 10 && jog_motor_on !== 1'b1; i++) cyc(1);
      chk("jog on", 1, jog_motor_on);
      for (int i = 0; i < 5000 && ramp_out !== t; i++) cyc(1);
      chk("ramp target", t, ramp_out);
      @(posedge ref_clk) jog <= 2'h0;
      for (int i = 0; i < 5000 && jog_motor_on !== 1'b0; i++) cyc(1);
      chk("jog off", 0, jog_motor_on);
      chk("ramp stop", 0, ramp_out);
    end
    @(posedge ref_clk) begin
      motor_on_other <= 1'b1;
      jog <= 2'h1;
    end
    cyc(12);
    chk("jog refused", 0, jog_motor_on);
    @(posedge ref_clk) jog <= 2'h0;
    cyc(8);
    @(posedge ref_clk) motor_on_other <= 1'b0;
    cyc(4);
    chk("jog stays off", 0, jog_motor_on);
    set_sel(2'h1);
    set_sel(2'h3);
    set_sel(2'h0);
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk) begin
        phase <= (i == 0) ? 4'h0 : 4'hF;
        count_req <= (i == 0) ? 3'h3 : ((i == 1) ? 3'h5 : 3'h4);
      end
      cyc(4);
      @(posedge ref_clk) phase <= 4'h0;
      cyc(2);
      cnt = (i == 2) ? 4 : 2;
      chk("set count", cnt, count);
    end
    set_sel(2'h3);
    set_sel(2'h2);
    for (int k = 0; k < 2; k++) begin
      sb = 0;
      @(posedge ref_clk) cp <= '{2'($urandom_range(0, 3)), 2'($urandom_range(0, 3)), 1'b1};
      for (int i = 0; i < 6 && copy_done !== 1'b1; i++) begin
        cyc(1);
        if (copy_busy === 1'b1) sb = 1;
      end
      chk("copy busy", 1, sb);
      chk("copy done", 1, copy_done);
      @(posedge ref_clk) cp.start <= 1'b0;
      cyc(3);
      chk("copy idle", 0, copy_done);
    end
    print_verdict();
  end
endmodule

// ===== tb/jcs_partner.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Terminal inputs of the higher-level controller
// ------------------------------------------------------------
module jcs_partner
  import jcs_pkg::*;
(
  // Clock
  input  wire logic       ref_clk,
  // Controller intent
  input  wire logic       ready_to_start,
  input  wire logic [1:0] jog,
  input  wire logic [1:0] idx,
  // Pins
  output logic [7:0]      dig_in = 8'h50
);
  always @(posedge ref_clk) begin
    dig_in[1:0] <= ready_to_start ? jog : 2'h0;
    dig_in[3:2] <= idx;
    dig_in[7:4] <= ~dig_in[7:4];
  end
endmodule
